// ===== verif/tb_wdc_watchdog_ctrl.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// self-checking bench for the watchdog control block
module tb_wdc_watchdog_ctrl;
  // design ports
  logic CORE_CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic guard = 1'b0;
  logic DEBUG_MODE = 1'b0;
  logic BOOT_DONE = 1'b0;
  logic [7:0] fuse = 8'h00;
  logic restart = 1'b0;
  logic WDT_CLK_TICK = 1'b0;
  logic SYSTEM_RESET_REQ;
  logic CONTROL_BUSY;
  logic CONFIG_LOCKED;
  // bench state
  int n_errors = 0;
  int check_count = 0;
  logic [1:0] tick_div = 2'h0;
  logic [7:0] hits;
  int n;
  wdc_watchdog_ctrl DUT (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CONFIG_CHANGE_GUARD_OPEN(guard), .DEBUG_MODE(DEBUG_MODE),
    .BOOT_DONE(BOOT_DONE), .BOOT_FUSE_WATCHDOG_SETTING(fuse),
    .WATCHDOG_RESTART_INSTRUCTION(restart), .WDT_CLK_TICK(WDT_CLK_TICK),
    .SYSTEM_RESET_REQ(SYSTEM_RESET_REQ), .CONTROL_BUSY(CONTROL_BUSY),
    .CONFIG_LOCKED(CONFIG_LOCKED));
  always #4 CORE_CLK = ~CORE_CLK;
  // watchdog tick every fourth core cycle
  always @(posedge CORE_CLK) begin
    tick_div <= tick_div + 2'h1;
    WDT_CLK_TICK <= (tick_div == 2'h3);
  end
  ////////////////////////////////////////////////////////////////////////////
  // compare an eight-bit value
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one register write with the guard level given
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic g);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    guard <= g;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
    guard <= 1'b0;
  endtask
  // one register read compared against an expected value
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 chk8(REG_RDATA, exp);
  endtask
  // wait for the crossing to finish, bounded
  task automatic wait_idle();
    // let the strobe edge settle before looking at busy
    #1;
    for (int i = 0; i < 100 && CONTROL_BUSY !== 1'b0; i++) begin
      @(posedge CORE_CLK);
      #1;
    end
    chk8({7'h00, CONTROL_BUSY}, 8'h00);
  endtask
  // restart pulse then count reset requests over c cycles
  task automatic kick_count(input logic k, input int c, output logic [7:0] h);
    h = 8'h00;
    @(posedge CORE_CLK);
    restart <= k;
    @(posedge CORE_CLK);
    restart <= 1'b0;
    repeat (c) begin
      @(posedge CORE_CLK);
      #1;
      if (SYSTEM_RESET_REQ === 1'b1) h++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    rdc(8'h00, 8'h00);
    rdc(8'h01, 8'h00);
    $display("test boot done");
  endtask
  task automatic t_busy();
    wr(8'h00, 8'h01, 1'b0);
    rdc(8'h00, 8'h00);
    wr(8'h00, 8'h01, 1'b1);
    rdc(8'h01, 8'h01);
    wr(8'h00, 8'h02, 1'b1);
    wait_idle();
    rdc(8'h00, 8'h01);
    rdc(8'h01, 8'h00);
    rdc(8'h05, 8'h00);
    wr(8'h01, 8'h7E, 1'b1);
    rdc(8'h01, 8'h00);
    $display("test busy done");
  endtask
  // every timeout code: reset request after 8 << (k-1) ticks
  task automatic t_plain();
    // stop the running watchdog so no stale pulse lands in the count
    wr(8'h00, 8'h00, 1'b1);
    wait_idle();
    for (int k = 1; k <= 11; k++) begin
      wr(8'h00, 8'(k), 1'b1);
      wait_idle();
      n = 0;
      while (SYSTEM_RESET_REQ !== 1'b1 && n < 40000) begin
        @(posedge CORE_CLK);
        #1 n++;
      end
      chk8(8'(n >= (32 << (k - 1)) - 4 && n <= (32 << (k - 1)) + 4),
        8'h01);
    end
    wr(8'h00, 8'h01, 1'b1);
    wait_idle();
    n = 0;
    repeat (8) begin
      kick_count(1'b1, 10, hits);
      n += hits;
    end
    chk8(8'(n), 8'h00);
    $display("test plain done");
  endtask
  task automatic t_window();
    wr(8'h00, 8'h11, 1'b1);
    wait_idle();
    kick_count(1'b1, 50, hits);
    chk8(hits, 8'h00);
    kick_count(1'b1, 14, hits);
    chk8(hits, 8'h00);
    kick_count(1'b1, 20, hits);
    chk8(hits, 8'h01);
    $display("test window done");
  endtask
  task automatic t_lock();
    wr(8'h01, 8'h80, 1'b0);
    rdc(8'h01, 8'h00);
    wr(8'h01, 8'h80, 1'b1);
    rdc(8'h01, 8'h80);
    wr(8'h00, 8'h00, 1'b1);
    rdc(8'h00, 8'h11);
    wr(8'h01, 8'h7F, 1'b1);
    rdc(8'h01, 8'h80);
    @(posedge CORE_CLK);
    DEBUG_MODE <= 1'b1;
    wr(8'h01, 8'h00, 1'b1);
    DEBUG_MODE <= 1'b0;
    rdc(8'h01, 8'h00);
    @(posedge CORE_CLK);
    BOOT_DONE <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    rdc(8'h01, 8'h80);
    chk8({7'h00, CONFIG_LOCKED}, 8'h01);
    $display("test lock done");
  endtask
  task automatic t_fuse();
    @(posedge CORE_CLK);
    SRST <= 1'b1;
    fuse <= 8'h05;
    BOOT_DONE <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    rdc(8'h00, 8'h05);
    rdc(8'h01, 8'h80);
    $display("test fuse done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge CORE_CLK);
    SRST <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    t_boot();
    t_busy();
    t_plain();
    t_window();
    t_lock();
    t_fuse();
    give_verdict();
  end
  // watchdog against a hang
  initial begin
    #800000;
    n_errors++;
    give_verdict();
  end
endmodule
bind wdc_watchdog_ctrl wdc_watchdog_ctrl_chk u_chk (.CORE_CLK(CORE_CLK),
  .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CONFIG_CHANGE_GUARD_OPEN(CONFIG_CHANGE_GUARD_OPEN),
  .DEBUG_MODE(DEBUG_MODE), .BOOT_DONE(BOOT_DONE),
  .WDT_CLK_TICK(WDT_CLK_TICK), .SYSTEM_RESET_REQ(SYSTEM_RESET_REQ),
  .CONTROL_BUSY(CONTROL_BUSY), .CONFIG_LOCKED(CONFIG_LOCKED));

// ===== verif/wdc_watchdog_ctrl_chk.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// watches register answers, busy flag, lock bit and reset request pulses
module wdc_watchdog_ctrl_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // processor side
  input wire logic CONFIG_CHANGE_GUARD_OPEN,
  input wire logic DEBUG_MODE,
  input wire logic BOOT_DONE,
  input wire logic WDT_CLK_TICK,
  // results
  input wire logic SYSTEM_RESET_REQ,
  input wire logic CONTROL_BUSY,
  input wire logic CONFIG_LOCKED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////
  // read data only in the cycle after a read strobe
  property p_rdata_idle;
    !$past(REG_RD) |-> REG_RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle");
  // status reads lock, zeros and busy
  property p_rd_status;
    REG_RD && REG_ADDR == 8'h01 |=>
      REG_RDATA == {$past(CONFIG_LOCKED), 6'h00, $past(CONTROL_BUSY)};
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("status read wrong");
  // unmapped reads return zero
  property p_rd_unmapped;
    REG_RD && REG_ADDR > 8'h01 |=> REG_RDATA == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  // accepted control write raises busy
  property p_busy_set;
    REG_WR && REG_ADDR == 8'h00 && CONFIG_CHANGE_GUARD_OPEN &&
      !CONFIG_LOCKED && !CONTROL_BUSY |=> CONTROL_BUSY;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("busy not set by write");
  // busy clears within a bounded time
  property p_busy_bound;
    $rose(CONTROL_BUSY) |-> ##[1:1000] !CONTROL_BUSY;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy stuck");
  // busy falls only after a watchdog tick
  property p_busy_tick;
    $fell(CONTROL_BUSY) && !$past(SRST) |->
      $past(WDT_CLK_TICK) || $past(WDT_CLK_TICK, 2);
  endproperty
  a_busy_tick: assert property (p_busy_tick)
    else $error("busy fell without tick");
  // locked control write is refused
  property p_ctrl_locked;
    REG_WR && REG_ADDR == 8'h00 && CONFIG_LOCKED && !CONTROL_BUSY
      |=> !CONTROL_BUSY;
  endproperty
  a_ctrl_locked: assert property (p_ctrl_locked)
    else $error("locked control accepted");
  // lock stays set outside debug
  property p_lock_sticky;
    CONFIG_LOCKED && !DEBUG_MODE |=> CONFIG_LOCKED;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock cleared outside debug");
  // guarded lock write sets lock
  property p_lock_set;
    REG_WR && REG_ADDR == 8'h01 && CONFIG_CHANGE_GUARD_OPEN &&
      REG_WDATA[7] |=> CONFIG_LOCKED;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock write not taken");
  // unguarded lock write is ignored
  property p_lock_guard;
    !CONFIG_LOCKED && REG_WR && REG_ADDR == 8'h01 &&
      !CONFIG_CHANGE_GUARD_OPEN && $stable(BOOT_DONE) |=> !CONFIG_LOCKED;
  endproperty
  a_lock_guard: assert property (p_lock_guard)
    else $error("unguarded lock write taken");
  // reset request is a single pulse
  property p_req_pulse;
    SYSTEM_RESET_REQ |=> !SYSTEM_RESET_REQ;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("reset request too long");
endmodule

// ===== verilog/wdc_period_counter.sv
`timescale 1ns/1ns
// down counter of watchdog ticks with a one-cycle expiry pulse
module wdc_period_counter #(
  parameter int WIDTH = 14
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic tick,
  // status
  output logic expired
);

  // the longest code needs 14 bits
  initial begin
    if (WIDTH < 14) begin
      $error("wdc_period_counter: WIDTH too small");
    end
  end

  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
  localparam logic [WIDTH-1:0] ZERO = WIDTH'(0);

  logic [WIDTH-1:0] count_reg; // ticks left, zero when idle
  logic expired_reg; // expiry pulse

  // load wins over counting; stops at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= ZERO;
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= 1'b0;
      if (load) begin
        count_reg <= load_value;
      end else if (tick && count_reg != ZERO) begin
        count_reg <= count_reg - ONE;
        expired_reg <= (count_reg == ONE);
      end
    end
  end

  assign expired = expired_reg;

endmodule

// ===== verilog/wdc_pkg.sv
package wdc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] WDC_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] WDC_STAT_OFFSET = 8'h01;
  localparam logic [7:0] WDC_STAT_RESET = 8'h00;
  localparam logic [7:0] WDC_CTRL_RESET = 8'h00;
  localparam logic [7:0] WDC_RDATA_IDLE = 8'h00;

  // control field positions
  localparam int WDC_WIN_LSB = 4;
  localparam int WDC_WIN_MSB = 7;
  localparam int WDC_PER_LSB = 0;
  localparam int WDC_PER_MSB = 3;

  // status field positions
  localparam int WDC_LOCK_BIT = 7;
  localparam int WDC_BUSY_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // timing, in watchdog clock ticks
  localparam int WDC_CNT_WIDTH = 14;
  localparam int WDC_SYNC_TICKS = 2;
  localparam logic [3:0] WDC_CODE_OFF = 4'h0;
  localparam logic [3:0] WDC_CODE_MIN = 4'h1;
  localparam logic [3:0] WDC_CODE_MAX = 4'hB;
  localparam logic [13:0] WDC_MIN_TICKS = 14'h0008;
  localparam logic [13:0] WDC_MAX_TICKS = 14'h2000;

  ////////////////////////////////////////////////////////////////////////
  // supervision states, one-hot
  typedef enum logic [4:0] {
    WDC_ST_OFF = 5'h01,
    WDC_ST_NORMAL = 5'h02,
    WDC_ST_CLOSED = 5'h04,
    WDC_ST_OPEN = 5'h08,
    WDC_ST_HALT = 5'h10
  } wdc_state_t;

  // field code to tick count; reserved codes run the longest length
  function automatic logic [13:0] wdc_code_ticks(input logic [3:0] code);
    logic [13:0] ticks;
    ticks = WDC_MAX_TICKS;
    if (code >= WDC_CODE_MIN && code <= WDC_CODE_MAX) begin
      ticks = WDC_MIN_TICKS << (code - WDC_CODE_MIN);
    end
    return ticks;
  endfunction

endpackage

// ===== verilog/wdc_tick_sync.sv
`timescale 1ns/1ns
// counts a fixed number of watchdog ticks after a start pulse
module wdc_tick_sync #(
  parameter int TICKS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic tick,
  // status
  output logic busy,
  output logic done
);

  // refuse a count the counter cannot hold
  initial begin
    if (TICKS < 1 || TICKS > 15) begin
      $error("wdc_tick_sync: TICKS out of range");
    end
  end

  localparam logic [3:0] LAST = 4'(TICKS - 1);

  logic [3:0] count_reg; // ticks seen so far
  logic busy_reg; // crossing in progress
  logic done_reg; // one-cycle end marker

  // busy and tick count; a start while busy is ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      count_reg <= 4'h0;
    end else if (!busy_reg) begin
      if (start) begin
        busy_reg <= 1'b1;
        count_reg <= 4'h0;
      end
    end else if (tick) begin
      if (count_reg == LAST) begin
        busy_reg <= 1'b0;
      end else begin
        count_reg <= count_reg + 4'h1;
      end
    end
  end

  // done pulse when the last tick lands
  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && tick && (count_reg == LAST);
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

// ===== verilog/wdc_watchdog_ctrl.sv
// Chosen here: strobed register access.
`timescale 1ns/1ns
// watchdog control and status with window and timeout supervision
module wdc_watchdog_ctrl (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // processor side
  input wire logic CONFIG_CHANGE_GUARD_OPEN,
  input wire logic DEBUG_MODE,
  input wire logic BOOT_DONE,
  input wire logic [7:0] BOOT_FUSE_WATCHDOG_SETTING,
  input wire logic WATCHDOG_RESTART_INSTRUCTION,
  // watchdog clock tick
  input wire logic WDT_CLK_TICK,
  // supervision result
  output logic SYSTEM_RESET_REQ,
  output logic CONTROL_BUSY,
  output logic CONFIG_LOCKED
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // register state
  logic [7:0] ctrl_reg; // control as software sees it
  logic lock_reg; // configuration lock
  logic boot_loaded_reg; // fuse value taken
  logic boot_done_q_reg; // boot done, last cycle
  logic [7:0] rdata_reg; // read data register

  // watchdog side state
  logic [7:0] eff_ctrl_reg; // control in effect for supervision
  logic cfg_changed_reg; // pulse after a crossing completes
  logic debug_q_reg; // debug mode, last cycle
  wdc_pkg::wdc_state_t state_reg;
  wdc_pkg::wdc_state_t state_next;
  logic reset_req_reg; // system reset pulse

  // decode and handshakes
  logic boot_load; // first cycle after reset release
  logic boot_done_rise; // boot code completed
  logic wr_ctrl; // write aimed at control
  logic wr_stat; // write aimed at status
  logic rd_ctrl; // read of control
  logic rd_stat; // read of status
  logic ctrl_accept; // control write taken
  logic sync_busy; // control value crossing
  logic sync_done; // crossing finished
  logic restart_busy; // restart crossing
  logic restart_done; // restart arrived in watchdog domain
  logic restart_start; // restart to start crossing

  // supervision helpers
  logic [3:0] eff_period; // timeout code in effect
  logic [3:0] eff_window; // closed window code in effect
  logic wd_enabled; // watchdog running
  logic win_mode; // window supervision selected
  logic [13:0] period_ticks; // open or plain timeout length
  logic [13:0] window_ticks; // closed interval length
  logic cnt_load; // counter reload
  logic [13:0] cnt_value; // counter reload value
  logic cnt_expired; // current interval elapsed
  logic fire; // raise a system reset

  ////////////////////////////////////////////////////////////////////////
  // register address decode

  // one decode per strobe; unmapped addresses hit nothing
  assign wr_ctrl = REG_WR && (REG_ADDR == wdc_pkg::WDC_CTRL_OFFSET);
  assign wr_stat = REG_WR && (REG_ADDR == wdc_pkg::WDC_STAT_OFFSET);
  assign rd_ctrl = REG_RD && (REG_ADDR == wdc_pkg::WDC_CTRL_OFFSET);
  assign rd_stat = REG_RD && (REG_ADDR == wdc_pkg::WDC_STAT_OFFSET);

  // control write needs the guard, no lock, and no crossing in flight
  assign ctrl_accept = wr_ctrl && CONFIG_CHANGE_GUARD_OPEN
                       && !lock_reg
                       && !sync_busy;

  ////////////////////////////////////////////////////////////////////////
  // boot handling

  // fuse value is taken once, in the first cycle after reset release
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      boot_loaded_reg <= 1'b0;
    end else begin
      boot_loaded_reg <= 1'b1;
    end
  end

  assign boot_load = !boot_loaded_reg;

  // edge of the boot done level
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      boot_done_q_reg <= 1'b0;
    end else begin
      boot_done_q_reg <= BOOT_DONE;
    end
  end

  assign boot_done_rise = BOOT_DONE && !boot_done_q_reg;

  ////////////////////////////////////////////////////////////////////////
  // control register

  // fuse load at start-up, then guarded software writes
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_reg <= wdc_pkg::WDC_CTRL_RESET;
    end else if (boot_load) begin
      ctrl_reg <= BOOT_FUSE_WATCHDOG_SETTING;
    end else if (ctrl_accept) begin
      ctrl_reg <= REG_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock bit

  // set wins over clear; clearing only from debug mode
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      lock_reg <= wdc_pkg::WDC_STAT_RESET[wdc_pkg::WDC_LOCK_BIT];
    end else if (boot_load) begin
      // a running fuse setting starts locked
      lock_reg <= (BOOT_FUSE_WATCHDOG_SETTING[3:0] !=
                   wdc_pkg::WDC_CODE_OFF);
    end else if (boot_done_rise && ctrl_reg[3:0] != wdc_pkg::WDC_CODE_OFF)
    begin
      lock_reg <= 1'b1;
    end else if (wr_stat && CONFIG_CHANGE_GUARD_OPEN) begin
      if (REG_WDATA[wdc_pkg::WDC_LOCK_BIT]) begin
        lock_reg <= 1'b1;
      end else if (DEBUG_MODE) begin
        lock_reg <= 1'b0;
      end
      // a zero outside debug mode leaves the lock alone
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control value crossing into the watchdog domain

  // busy rises with the accepted write, drops after the ticks
  wdc_tick_sync #(
    .TICKS(wdc_pkg::WDC_SYNC_TICKS)
  ) u_ctrl_sync (
    .clk(CORE_CLK),
    .rst(SRST),
    .start(ctrl_accept),
    .tick(WDT_CLK_TICK),
    .busy(sync_busy),
    .done(sync_done)
  );

  // value in effect; fuse setting is in effect straight away
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      eff_ctrl_reg <= wdc_pkg::WDC_CTRL_RESET;
      cfg_changed_reg <= 1'b0;
    end else begin
      cfg_changed_reg <= sync_done;
      if (boot_load) begin
        eff_ctrl_reg <= BOOT_FUSE_WATCHDOG_SETTING;
      end else if (sync_done) begin
        eff_ctrl_reg <= ctrl_reg;
      end
    end
  end

  assign eff_period = eff_ctrl_reg[wdc_pkg::WDC_PER_MSB:wdc_pkg::WDC_PER_LSB];
  assign eff_window = eff_ctrl_reg[wdc_pkg::WDC_WIN_MSB:wdc_pkg::WDC_WIN_LSB];
  assign wd_enabled = (eff_period != wdc_pkg::WDC_CODE_OFF);
  assign win_mode = (eff_window != wdc_pkg::WDC_CODE_OFF);
  assign period_ticks = wdc_pkg::wdc_code_ticks(eff_period);
  assign window_ticks = wdc_pkg::wdc_code_ticks(eff_window);

  ////////////////////////////////////////////////////////////////////////
  // restart crossing

  // a restart while one is still crossing is dropped
  assign restart_start = WATCHDOG_RESTART_INSTRUCTION && !restart_busy;

  wdc_tick_sync #(
    .TICKS(wdc_pkg::WDC_SYNC_TICKS)
  ) u_restart_sync (
    .clk(CORE_CLK),
    .rst(SRST),
    .start(restart_start),
    .tick(WDT_CLK_TICK),
    .busy(restart_busy),
    .done(restart_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // interval counter

  wdc_period_counter #(
    .WIDTH(wdc_pkg::WDC_CNT_WIDTH)
  ) u_counter (
    .clk(CORE_CLK),
    .rst(SRST),
    .load(cnt_load),
    .load_value(cnt_value),
    .tick(WDT_CLK_TICK),
    .expired(cnt_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // supervision state machine

  // debug mode level, last cycle
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      debug_q_reg <= 1'b0;
    end else begin
      debug_q_reg <= DEBUG_MODE;
    end
  end

  // next state, counter reload and reset decision
  always_comb begin
    state_next = state_reg;
    cnt_load = 1'b0;
    cnt_value = period_ticks;
    fire = 1'b0;
    if (DEBUG_MODE) begin
      // halted: counter held fresh, restarts ignored
      state_next = wdc_pkg::WDC_ST_HALT;
      cnt_load = 1'b1;
    end else if (cfg_changed_reg && state_reg != wdc_pkg::WDC_ST_HALT) begin
      // new setting: first closed window waits for a restart
      cnt_load = 1'b1;
      if (wd_enabled) begin
        state_next = wdc_pkg::WDC_ST_NORMAL;
      end else begin
        state_next = wdc_pkg::WDC_ST_OFF;
      end
    end else begin
      case (state_reg)
        wdc_pkg::WDC_ST_HALT: begin
          // leaving debug runs a plain timeout first
          cnt_load = 1'b1;
          if (wd_enabled && debug_q_reg) begin
            state_next = wdc_pkg::WDC_ST_NORMAL;
          end else if (!wd_enabled) begin
            state_next = wdc_pkg::WDC_ST_OFF;
          end else begin
            state_next = wdc_pkg::WDC_ST_NORMAL;
          end
        end
        wdc_pkg::WDC_ST_OFF: begin
          // idle until enabled
          if (wd_enabled) begin
            state_next = wdc_pkg::WDC_ST_NORMAL;
            cnt_load = 1'b1;
          end
        end
        wdc_pkg::WDC_ST_NORMAL: begin
          if (restart_done) begin
            cnt_load = 1'b1;
            if (win_mode) begin
              // first restart opens the closed interval
              state_next = wdc_pkg::WDC_ST_CLOSED;
              cnt_value = window_ticks;
            end else begin
              cnt_value = period_ticks;
            end
          end else if (cnt_expired) begin
            fire = 1'b1;
            cnt_load = 1'b1;
          end
        end
        wdc_pkg::WDC_ST_CLOSED: begin
          if (restart_done) begin
            // too early
            fire = 1'b1;
            cnt_load = 1'b1;
            state_next = wdc_pkg::WDC_ST_NORMAL;
          end else if (cnt_expired) begin
            state_next = wdc_pkg::WDC_ST_OPEN;
            cnt_load = 1'b1;
            cnt_value = period_ticks;
          end
        end
        wdc_pkg::WDC_ST_OPEN: begin
          if (restart_done) begin
            // accepted restart begins the next closed interval
            state_next = wdc_pkg::WDC_ST_CLOSED;
            cnt_load = 1'b1;
            cnt_value = window_ticks;
          end else if (cnt_expired) begin
            // too late
            fire = 1'b1;
            cnt_load = 1'b1;
            state_next = wdc_pkg::WDC_ST_NORMAL;
          end
        end
        default: begin
          state_next = wdc_pkg::WDC_ST_OFF;
          cnt_load = 1'b1;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg <= wdc_pkg::WDC_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // system reset request pulse
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_reg <= wdc_pkg::WDC_RDATA_IDLE;
    end else if (rd_ctrl) begin
      rdata_reg <= ctrl_reg;
    end else if (rd_stat) begin
      // busy readable without any unlock
      rdata_reg <= {lock_reg, 6'h00, sync_busy};
    end else begin
      rdata_reg <= wdc_pkg::WDC_RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign REG_RDATA = rdata_reg;
  assign SYSTEM_RESET_REQ = reset_req_reg;
  assign CONTROL_BUSY = sync_busy;
  assign CONFIG_LOCKED = lock_reg;

endmodule
